// ### inc/osc_wake_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock and a 32-bit apb register bus
`ifndef OSC_WAKE_REGS_SVH
`define OSC_WAKE_REGS_SVH

`define OFS_TRIM            12'h000
`define OFS_CTRL            12'h004
`define OFS_STATUS          12'h008
`define OFS_WAKE            12'h00C

`define TRIM_RESET          8'h00
`define TRIM_SRC_BIT        7
`define TRIM_MULT_BIT       6
`define TRIM_CODE_W         6
`define TRIM_CODE_MAX       6'h1F
`define TRIM_CODE_MIN       6'h20

`define CTRL_RESET          8'h00
`define CTRL_FSEL_LSB       0
`define CTRL_MSEL_BIT       3
`define CTRL_INTOSC_BIT     4
`define CTRL_FAIL_SAFE_CLOCK_MONITOR_BIT       5

`define FSEL_LOW_ONLY       3'h0
`define FSEL_MID_LAST       3'h2

`define PREP_TIME_NS        200
`define CLK_PERIOD_NS       10
`define PREP_CYCLES         ((`PREP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STARTUP_CYCLES      1024
`define TRIM_STEP_CYCLES    16

`endif

// ### inc/osc_wake_pkg.sv
// types shared by the oscillator and wake control files
// holds no constants; those live in the register header
package osc_wake_pkg;
   typedef enum logic [1:0] {
      OSC_LOW  = 2'b00,
      OSC_MED  = 2'b01,
      OSC_HIGH = 2'b10
   } osc_sel_t;

   typedef enum logic [2:0] {
      PM_RUN     = 3'b000,
      PM_ASLEEP  = 3'b001,
      PM_STARTUP = 3'b010,
      PM_PREPARE = 3'b011,
      PM_RESTART = 3'b100
   } pm_state_t;

   typedef enum logic [1:0] {
      WAKE_NONE  = 2'b00,
      WAKE_IRQ   = 2'b01,
      WAKE_RESET = 2'b10,
      WAKE_WDT   = 2'b11
   } wake_cause_t;
endpackage

// ### rtl/osc_select.sv
// internal oscillator choice and its stability flag
// inputs come from the same clock domain, already synchronised
`timescale 1ns/1ns
`default_nettype none
`include "osc_wake_regs.svh"
module osc_select (
   input  wire logic                  fsel_in,
   input  wire logic [2:0]            freq_select_in,
   input  wire logic                  src_select_in,
   input  wire logic                  med_select_in,
   input  wire logic                  low_stable_in,
   input  wire logic                  med_stable_in,
   input  wire logic                  high_stable_in,
   output osc_wake_pkg::osc_sel_t     sel_out,
   output logic                       stable_out
);
   import osc_wake_pkg::*;

   always_comb begin
      if (freq_select_in == `FSEL_LOW_ONLY && !src_select_in) begin
         sel_out = OSC_LOW;
      end else if (freq_select_in <= `FSEL_MID_LAST) begin
         sel_out = med_select_in ? OSC_MED : OSC_HIGH;
      end else begin
         sel_out = OSC_HIGH;
      end
   end

   always_comb begin
      case (sel_out)
         OSC_LOW:  stable_out = low_stable_in;
         OSC_MED:  stable_out = med_stable_in;
         OSC_HIGH: stable_out = high_stable_in;
         default:  stable_out = 1'b0;
      endcase
   end

   // fsel_in kept for symmetry with the wake path; unused here
   logic unused_fsel;
   assign unused_fsel = fsel_in;
endmodule // osc_select
`default_nettype wire

// ### rtl/trim_slew.sv
// walks the applied trim toward the requested code one step at a time
// the analog oscillator takes the applied code; no completion flag exists
`timescale 1ns/1ns
`default_nettype none
`include "osc_wake_regs.svh"
module trim_slew #(
   parameter int STEP_CYCLES = `TRIM_STEP_CYCLES
) (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [5:0]  target_in,
   output logic      [5:0]  applied_out
);
   logic [15:0] tick_q;
   logic        step;
   logic signed [5:0] tgt_s;
   logic signed [5:0] cur_s;

   assign step  = (tick_q == 16'(STEP_CYCLES - 1));
   assign tgt_s = signed'(target_in);
   assign cur_s = signed'(applied_out);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_q <= 16'h0000;
      end else if (step) begin
         tick_q <= 16'h0000;
      end else begin
         tick_q <= tick_q + 16'h0001;
      end
   end

   // signed compare keeps the walk monotonic through 000000
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         applied_out <= 6'h00;
      end else if (step && cur_s < tgt_s) begin
         applied_out <= applied_out + 6'h01;
      end else if (step && cur_s > tgt_s) begin
         applied_out <= applied_out - 6'h01;
      end
   end
endmodule // trim_slew
`default_nettype wire

// ### rtl/osc_wake_ctrl.sv
// oscillator trim register, oscillator choice and sleep/idle wake sequencing
// Function
// - six-bit signed trim, resets to zero
// - trim write slews oscillator, no done flag
// - trim never touches low oscillator
// - 011111 max, 100000 min, 000000 calibrated
// - bit 7 picks low-frequency clock source
// - bit 6 enables the 4x multiplier
// - multiplier applies to every primary source
// - decode frequency, source, medium selects
// - stable only when chosen oscillator stable
// - wake only on interrupt, reset, watchdog
// - enabled interrupt flag starts the wake
// - next instruction first, vector if enabled
// - prepare delay then execution resumes
// - watchdog wakes when asleep, resets when running
// - four events clear the watchdog counter
// - reset wake restarts at address zero
// - skip startup timer when clock already fine
// - active-low master clear resets the device
// assumes apb master on MCLK_IN; master clear, stable and clock-loss pins are synchronised here
`timescale 1ns/1ns
`default_nettype none
`include "osc_wake_regs.svh"
module osc_wake_ctrl #(
   parameter int PREP_CYCLES    = `PREP_CYCLES,
   parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
   parameter int TRIM_STEP      = `TRIM_STEP_CYCLES,
   parameter int IRQ_W          = 8
) (
   input  wire logic                 MCLK_IN,
   input  wire logic                 NRST_IN,
   input  wire logic                 PSEL_IN,
   input  wire logic                 PENABLE_IN,
   input  wire logic                 PWRITE_IN,
   input  wire logic [11:0]          PADDR_IN,
   input  wire logic [31:0]          PWDATA_IN,
   output logic      [31:0]          PRDATA_OUT,
   output logic                      PREADY_OUT,
   output logic                      PSLVERR_OUT,
   input  wire logic                 MASTER_CLEAR_N_IN,
   input  wire logic                 LOW_OSC_STABLE_IN,
   input  wire logic                 MED_OSC_STABLE_IN,
   input  wire logic                 HIGH_OSC_STABLE_IN,
   input  wire logic                 CLOCK_LOSS_IN,
   input  wire logic [IRQ_W-1:0]     IRQ_FLAGS_IN,
   input  wire logic [IRQ_W-1:0]     IRQ_ENABLES_IN,
   input  wire logic                 GLOBAL_IRQ_ENABLE_IN,
   input  wire logic                 SLEEP_INSTR_IN,
   input  wire logic                 IDLE_SEL_IN,
   input  wire logic                 WDT_CLEAR_INSTR_IN,
   input  wire logic                 WDT_TIMEOUT_IN,
   input  wire logic                 PRIMARY_IS_CRYSTAL_IN,
   output logic      [5:0]           HIGH_MED_TRIM_OUT,
   output logic                      LOW_FREQ_SOURCE_SELECT_OUT,
   output logic                      MULTIPLIER_ENABLE_OUT,
   output osc_wake_pkg::osc_sel_t    OSC_SEL_OUT,
   output logic                      OSC_STABLE_OUT,
   output logic                      CPU_RUN_OUT,
   output logic                      CORE_CLOCK_RUN_OUT,
   output logic                      PRIMARY_RUN_OUT,
   output logic                      VECTOR_IRQ_OUT,
   output logic                      RESTART_AT_ZERO_OUT,
   output logic                      DEVICE_RESET_OUT,
   output logic                      WDT_RESET_OUT,
   output logic                      WDT_CLEAR_OUT,
   output osc_wake_pkg::wake_cause_t WAKE_CAUSE_OUT
);
   import osc_wake_pkg::*;

   logic        master_clear_n_meta_q;
   logic        master_clear_n_n_q;
   logic [2:0]  stab_meta_q;
   logic [2:0]  stab_q;
   logic        loss_meta_q;
   logic        loss_q;
   logic [7:0]  trim_q;
   logic [7:0]  ctrl_q;
   pm_state_t   state_q;
   pm_state_t   state_d;
   wake_cause_t cause_q;
   logic [15:0] cnt_q;
   logic        rst_n;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic        irq_wake;
   logic        wake_evt;
   logic        need_startup;
   logic        fsel_change_wr;
   logic        cnt_done;
   logic        sleeping;
   logic        pending_vector_q;
   logic        after_sleep_q;

   // master clear pin: two stages, then used as a synchronous reset
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         master_clear_n_meta_q <= 1'b0;
         master_clear_n_n_q    <= 1'b0;
         stab_meta_q <= 3'h0;
         stab_q      <= 3'h0;
         loss_meta_q <= 1'b0;
         loss_q      <= 1'b0;
      end else begin
         master_clear_n_meta_q <= MASTER_CLEAR_N_IN;
         master_clear_n_n_q    <= master_clear_n_meta_q;
         stab_meta_q <= {HIGH_OSC_STABLE_IN, MED_OSC_STABLE_IN, LOW_OSC_STABLE_IN};
         stab_q      <= stab_meta_q;
         loss_meta_q <= CLOCK_LOSS_IN;
         loss_q      <= loss_meta_q;
      end
   end
   assign rst_n            = master_clear_n_n_q;
   assign DEVICE_RESET_OUT = !master_clear_n_n_q;

   // apb slave: zero wait states, unmapped addresses error
   assign PREADY_OUT = 1'b1;
   assign addr_ok    = (PADDR_IN == `OFS_TRIM) || (PADDR_IN == `OFS_CTRL) ||
                       (PADDR_IN == `OFS_STATUS) || (PADDR_IN == `OFS_WAKE);
   assign wr_en      = PSEL_IN && PENABLE_IN && PWRITE_IN;
   assign rd_en      = PSEL_IN && PENABLE_IN && !PWRITE_IN;
   assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_ok;

   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         trim_q <= `TRIM_RESET;
      end else if (!rst_n) begin
         trim_q <= `TRIM_RESET;
      end else if (wr_en && PADDR_IN == `OFS_TRIM) begin
         trim_q <= PWDATA_IN[7:0];
      end
   end

   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ctrl_q <= `CTRL_RESET;
      end else if (!rst_n) begin
         ctrl_q <= `CTRL_RESET;
      end else if (wr_en && PADDR_IN == `OFS_CTRL) begin
         ctrl_q <= {2'b00, PWDATA_IN[5:0]};
      end
   end

   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         PRDATA_OUT <= 32'h0000_0000;
      end else if (rd_en) begin
         case (PADDR_IN)
            `OFS_TRIM:   PRDATA_OUT <= {24'h000000, trim_q};
            `OFS_CTRL:   PRDATA_OUT <= {24'h000000, ctrl_q};
            `OFS_STATUS: PRDATA_OUT <= {26'h0, HIGH_MED_TRIM_OUT};
            `OFS_WAKE:   PRDATA_OUT <= {24'h0, OSC_STABLE_OUT, 1'b0, OSC_SEL_OUT,
                                        1'b0, cause_q, CPU_RUN_OUT};
            default:     PRDATA_OUT <= 32'h0000_0000;
         endcase
      end
   end

   // gradual shift of the high/medium oscillators only
   trim_slew #(
      .STEP_CYCLES (TRIM_STEP)
   ) u_slew (
      .clk_in      (MCLK_IN),
      .rst_n_in    (NRST_IN),
      .target_in   (trim_q[5:0]),
      .applied_out (HIGH_MED_TRIM_OUT)
   );

   assign LOW_FREQ_SOURCE_SELECT_OUT = trim_q[`TRIM_SRC_BIT];
   // multiplier is not gated by source type; 4-16 MHz input is software's duty
   assign MULTIPLIER_ENABLE_OUT      = trim_q[`TRIM_MULT_BIT];

   osc_select u_sel (
      .fsel_in        (1'b0),
      .freq_select_in (ctrl_q[2:0]),
      .src_select_in  (trim_q[`TRIM_SRC_BIT]),
      .med_select_in  (ctrl_q[`CTRL_MSEL_BIT]),
      .low_stable_in  (stab_q[0]),
      .med_stable_in  (stab_q[1]),
      .high_stable_in (stab_q[2]),
      .sel_out        (OSC_SEL_OUT),
      .stable_out     (OSC_STABLE_OUT)
   );

   // wake sources: only interrupt and watchdog here; reset wakes through the restart state
   assign irq_wake = |(IRQ_FLAGS_IN & IRQ_ENABLES_IN);
   assign sleeping = (state_q == PM_ASLEEP);
   assign wake_evt = sleeping && (irq_wake || WDT_TIMEOUT_IN);
   // crystal modes need the startup timer unless primary kept running
   assign need_startup = PRIMARY_IS_CRYSTAL_IN && !IDLE_SEL_IN;
   assign cnt_done     = (cnt_q == 16'h0000);

   always_comb begin
      state_d = state_q;
      case (state_q)
         PM_RUN:     if (SLEEP_INSTR_IN) state_d = PM_ASLEEP;
         PM_ASLEEP:  if (wake_evt) state_d = need_startup ? PM_STARTUP : PM_PREPARE;
         PM_STARTUP: if (cnt_done) state_d = PM_PREPARE;
         PM_PREPARE: if (cnt_done) state_d = PM_RUN;
         PM_RESTART: state_d = PM_RUN;
         default:    state_d = PM_RUN;
      endcase
   end

   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         state_q <= PM_RESTART;
      end else if (!rst_n) begin
         state_q <= PM_RESTART;
      end else begin
         state_q <= state_d;
      end
   end

   // one counter serves the startup timer and the prepare delay
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         cnt_q <= 16'h0000;
      end else if (sleeping && wake_evt) begin
         cnt_q <= need_startup ? 16'(STARTUP_CYCLES - 1) : 16'(PREP_CYCLES - 1);
      end else if (state_q == PM_STARTUP && cnt_done) begin
         cnt_q <= 16'(PREP_CYCLES - 1);
      end else if (!cnt_done) begin
         cnt_q <= cnt_q - 16'h0001;
      end
   end

   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         cause_q <= WAKE_RESET;
      end else if (!rst_n) begin
         cause_q <= WAKE_RESET;
      end else if (wake_evt) begin
         cause_q <= irq_wake ? WAKE_IRQ : WAKE_WDT;
      end
   end

   // vector decision latched at wake, raised after the post-sleep instruction
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         pending_vector_q <= 1'b0;
         after_sleep_q    <= 1'b0;
      end else if (!rst_n) begin
         pending_vector_q <= 1'b0;
         after_sleep_q    <= 1'b0;
      end else begin
         if (wake_evt) begin
            pending_vector_q <= irq_wake && GLOBAL_IRQ_ENABLE_IN;
         end else if (after_sleep_q) begin
            pending_vector_q <= 1'b0;
         end
         after_sleep_q <= (state_q == PM_PREPARE) && cnt_done;
      end
   end
   assign VECTOR_IRQ_OUT      = after_sleep_q && pending_vector_q;

   assign CPU_RUN_OUT         = (state_q == PM_RUN) && rst_n;
   assign CORE_CLOCK_RUN_OUT  = !sleeping || IDLE_SEL_IN;
   assign PRIMARY_RUN_OUT     = !sleeping || IDLE_SEL_IN;
   assign RESTART_AT_ZERO_OUT = (state_q == PM_RESTART);
   assign WDT_RESET_OUT       = WDT_TIMEOUT_IN && (state_q == PM_RUN) && rst_n;
   assign WAKE_CAUSE_OUT      = cause_q;

   assign fsel_change_wr = wr_en && PADDR_IN == `OFS_CTRL &&
                           PWDATA_IN[2:0] != ctrl_q[2:0] && ctrl_q[`CTRL_INTOSC_BIT];
   assign WDT_CLEAR_OUT  = SLEEP_INSTR_IN || WDT_CLEAR_INSTR_IN ||
                           (loss_q && ctrl_q[`CTRL_FAIL_SAFE_CLOCK_MONITOR_BIT]) || fsel_change_wr;
endmodule // osc_wake_ctrl
`default_nettype wire

// ### tb/osc_wake_chk.sv
// assertions on the trim register, oscillator choice and wake sequencing
// sees the top module's ports only; bound to every instance at the foot
`timescale 1ns/1ns
`default_nettype none
`include "osc_wake_regs.svh"
module osc_wake_chk
   import osc_wake_pkg::*;
#(
   parameter int IRQ_W = 8
) (
   input wire logic                       MCLK_IN,
   input wire logic                       NRST_IN,
   input wire logic                       PSEL_IN,
   input wire logic                       PENABLE_IN,
   input wire logic                       PWRITE_IN,
   input wire logic [11:0]                PADDR_IN,
   input wire logic [31:0]                PWDATA_IN,
   input wire logic                       PSLVERR_OUT,
   input wire logic                       MASTER_CLEAR_N_IN,
   input wire logic                       HIGH_OSC_STABLE_IN,
   input wire logic [IRQ_W-1:0]           IRQ_FLAGS_IN,
   input wire logic [IRQ_W-1:0]           IRQ_ENABLES_IN,
   input wire logic                       GLOBAL_IRQ_ENABLE_IN,
   input wire logic                       SLEEP_INSTR_IN,
   input wire logic                       WDT_CLEAR_INSTR_IN,
   input wire logic                       WDT_TIMEOUT_IN,
   input wire logic                       PRIMARY_IS_CRYSTAL_IN,
   input wire logic [5:0]                 HIGH_MED_TRIM_OUT,
   input wire logic                       LOW_FREQ_SOURCE_SELECT_OUT,
   input wire logic                       MULTIPLIER_ENABLE_OUT,
   input wire osc_wake_pkg::osc_sel_t     OSC_SEL_OUT,
   input wire logic                       OSC_STABLE_OUT,
   input wire logic                       CPU_RUN_OUT,
   input wire logic                       VECTOR_IRQ_OUT,
   input wire logic                       RESTART_AT_ZERO_OUT,
   input wire logic                       DEVICE_RESET_OUT,
   input wire logic                       WDT_RESET_OUT,
   input wire logic                       WDT_CLEAR_OUT,
   input wire osc_wake_pkg::wake_cause_t  WAKE_CAUSE_OUT
);
   logic [1:0] age_q;
   logic [5:0] prev_q;
   logic [5:0] dlt;
   logic       trim_wr;
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!NRST_IN);
   assign dlt = HIGH_MED_TRIM_OUT - prev_q;
   assign trim_wr = PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == `OFS_TRIM &&
                    !DEVICE_RESET_OUT;
   // age_q masks the synchroniser refill after either reset
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         age_q <= 2'h0;
         prev_q <= 6'h00;
      end else begin
         age_q <= DEVICE_RESET_OUT ? 2'h0 : age_q + {1'h0, age_q != 2'h3};
         prev_q <= HIGH_MED_TRIM_OUT;
      end
   end
   a_src_sel_write: assert property (trim_wr |=> LOW_FREQ_SOURCE_SELECT_OUT == $past(PWDATA_IN[7]))
      else $error("source select did not follow write");
   a_mult_write: assert property (trim_wr |=> MULTIPLIER_ENABLE_OUT == $past(PWDATA_IN[6]))
      else $error("multiplier enable did not follow write");
   a_trim_step: assert property (&age_q |-> dlt inside {6'h00, 6'h01, 6'h3F})
      else $error("applied trim jumped");
   a_low_needs_src: assert property (OSC_SEL_OUT == OSC_LOW |-> !LOW_FREQ_SOURCE_SELECT_OUT)
      else $error("low oscillator picked with source select set");
   a_high_stable: assert property (&age_q && OSC_SEL_OUT == OSC_HIGH
      && $stable(HIGH_OSC_STABLE_IN) && $past(HIGH_OSC_STABLE_IN, 2) == HIGH_OSC_STABLE_IN
      |-> OSC_STABLE_OUT == HIGH_OSC_STABLE_IN)
      else $error("stable flag not from high oscillator");
   a_wdt_run_reset: assert property (WDT_RESET_OUT == (WDT_TIMEOUT_IN && CPU_RUN_OUT))
      else $error("watchdog reset wrong for mode");
   a_wdt_clear: assert property (WDT_CLEAR_INSTR_IN || SLEEP_INSTR_IN && CPU_RUN_OUT |-> WDT_CLEAR_OUT)
      else $error("watchdog not cleared");
   a_prep_delay: assert property ($rose(|(IRQ_FLAGS_IN & IRQ_ENABLES_IN))
      && !CPU_RUN_OUT && !PRIMARY_IS_CRYSTAL_IN
      |-> (!CPU_RUN_OUT) [*8] ##[10:14] CPU_RUN_OUT)
      else $error("prepare delay length wrong");
   a_vector_fires: assert property ($rose(CPU_RUN_OUT) && WAKE_CAUSE_OUT == WAKE_IRQ
      && GLOBAL_IRQ_ENABLE_IN |-> ##[0:1] VECTOR_IRQ_OUT)
      else $error("no vector after interrupt wake");
   a_vector_gie: assert property (VECTOR_IRQ_OUT |-> GLOBAL_IRQ_ENABLE_IN && CPU_RUN_OUT)
      else $error("vector without global enable");
   // restart lasts one cycle past the synchronised master clear release
   a_restart_run: assert property (RESTART_AT_ZERO_OUT && !DEVICE_RESET_OUT |=> CPU_RUN_OUT)
      else $error("restart not followed by run");
   a_master_clear_n_resets: assert property (!MASTER_CLEAR_N_IN [*3] |-> DEVICE_RESET_OUT)
      else $error("master clear did not reset");
   a_bad_addr: assert property (PSEL_IN && PENABLE_IN |-> PSLVERR_OUT == (PADDR_IN > `OFS_WAKE || PADDR_IN[1:0] != 2'h0))
      else $error("error response wrong");
   c_vector: cover property (VECTOR_IRQ_OUT);
   c_bad_addr: cover property (PSLVERR_OUT);
   c_wdt_reset: cover property (WDT_RESET_OUT);
endmodule // osc_wake_chk
bind osc_wake_ctrl osc_wake_chk #(.IRQ_W(IRQ_W)) chk_i (.*);
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the oscillator trim and wake controller
// drives apb and the wake inputs itself; startup and trim step counts are shortened by parameter
`timescale 1ns/1ns
`default_nettype none
`include "osc_wake_regs.svh"
module testbench;
   import osc_wake_pkg::*;
   logic        clk, rst_n, psel, pen, pwr, pready, pslverr, master_clear_n_n, gie, slp, idle;
   logic        wclr, wto, xtal, lfs, mult, stab, run, vec, rz, drst, wrst, wcl, err;
   logic        lstab, mstab, hstab, closs, ccr, prr, wc;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [7:0]  flags, ens;
   logic [5:0]  trim;
   osc_sel_t    sel;
   wake_cause_t cause;
   int          fails, checked;
   osc_wake_ctrl #(.PREP_CYCLES(20), .STARTUP_CYCLES(8), .TRIM_STEP(2)) dut (
      .MCLK_IN(clk), .NRST_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .MASTER_CLEAR_N_IN(master_clear_n_n), .LOW_OSC_STABLE_IN(lstab),
      .MED_OSC_STABLE_IN(mstab), .HIGH_OSC_STABLE_IN(hstab), .CLOCK_LOSS_IN(closs),
      .IRQ_FLAGS_IN(flags), .IRQ_ENABLES_IN(ens), .GLOBAL_IRQ_ENABLE_IN(gie),
      .SLEEP_INSTR_IN(slp), .IDLE_SEL_IN(idle), .WDT_CLEAR_INSTR_IN(wclr), .WDT_TIMEOUT_IN(wto),
      .PRIMARY_IS_CRYSTAL_IN(xtal), .HIGH_MED_TRIM_OUT(trim), .LOW_FREQ_SOURCE_SELECT_OUT(lfs),
      .MULTIPLIER_ENABLE_OUT(mult), .OSC_SEL_OUT(sel), .OSC_STABLE_OUT(stab),
      .CPU_RUN_OUT(run), .CORE_CLOCK_RUN_OUT(ccr), .PRIMARY_RUN_OUT(prr), .VECTOR_IRQ_OUT(vec),
      .RESTART_AT_ZERO_OUT(rz), .DEVICE_RESET_OUT(drst), .WDT_RESET_OUT(wrst),
      .WDT_CLEAR_OUT(wcl), .WAKE_CAUSE_OUT(cause));
   task automatic chk(input logic [31:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      err = pslverr;
      wc = wcl;
      psel <= 1'h0;
      pen <= 1'h0;
      #1 rdv = prdata;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'h0, a, 32'h0);
      chk(rdv, exp, what);
   endtask
   // one sleep and wake; lo..hi bounds the cycles from trigger to run
   task automatic nap(input logic x, i, g, input wake_cause_t k, input int lo, hi);
      int n;
      logic v;
      v = 1'h0;
      @(posedge clk);
      xtal <= x;
      idle <= i;
      gie <= g;
      flags <= 8'h04;
      slp <= 1'h1;
      #1 chk(wcl, 1'h1, "sleep clear");
      @(posedge clk);
      slp <= 1'h0;
      tick(30);
      chk(run, 1'h0, "still asleep");
      chk({ccr, prr}, {i, i}, "clocks asleep");
      @(posedge clk);
      if (k == WAKE_IRQ) ens <= 8'h04;
      else wto <= 1'h1;
      #1 chk(wrst, 1'h0, "no reset asleep");
      @(posedge clk);
      wto <= 1'h0;
      #1 n = 1;
      while (n < 60 && run !== 1'h1) begin
         @(posedge clk);
         #1 n++;
      end
      repeat (4) begin
         v |= vec;
         tick(1);
      end
      chk(n >= lo && n <= hi, 1'h1, "wake delay");
      chk(cause, k, "wake cause");
      chk(v, k == WAKE_IRQ && g, "vector");
      chk({ccr, prr}, 2'h3, "clocks running");
      @(posedge clk);
      flags <= 8'h00;
      ens <= 8'h00;
   endtask
   task automatic t_regs();
      rd(`OFS_TRIM, 32'h0, "trim reset");
      apb(1'h1, `OFS_TRIM, 32'hDF);
      rd(`OFS_TRIM, 32'hDF, "trim readback");
      chk({lfs, mult}, 2'h3, "fields set");
      apb(1'h1, `OFS_TRIM, 32'h40);
      chk({lfs, mult}, 2'h1, "fields split");
      rd(12'h010, 32'h0, "unmapped read");
      chk(err, 1'h1, "unmapped error");
      $display("register test done");
   endtask
   task automatic t_slew();
      apb(1'h1, `OFS_TRIM, 32'h1F);
      tick(150);
      chk(trim, 6'h1F, "max code");
      apb(1'h1, `OFS_TRIM, 32'h20);
      chk(trim == 6'h20, 1'h0, "no jump");
      tick(150);
      chk(trim, 6'h20, "min code");
      rd(`OFS_STATUS, 32'h20, "applied status");
      apb(1'h1, `OFS_TRIM, 32'h00);
      tick(100);
      chk(trim, 6'h00, "calibrated code");
      $display("trim test done");
   endtask
   task automatic t_select();
      osc_sel_t e;
      logic [2:0] st;
      for (int f = 0; f < 8; f++)
         for (int m = 0; m < 2; m++)
            for (int s = 0; s < 2; s++) begin
               e = (f > 2 || m == 0) ? OSC_HIGH : OSC_MED;
               if (f == 0 && s == 0) e = OSC_LOW;
               // each oscillator is seen both stable and unstable while chosen
               st = f[2:0] ^ {s[0], m[0], m[0]};
               @(posedge clk);
               {hstab, mstab, lstab} <= st;
               apb(1'h1, `OFS_TRIM, {24'h0, s[0], 7'h00});
               apb(1'h1, `OFS_CTRL, {28'h0, m[0], f[2:0]});
               chk(sel, e, "osc choice");
               chk(stab, st[e], "osc stable");
            end
      apb(1'h1, `OFS_CTRL, 32'h10);
      chk(wc, 1'h0, "first intosc write");
      apb(1'h1, `OFS_CTRL, 32'h15);
      chk(wc, 1'h1, "freq select change");
      apb(1'h1, `OFS_CTRL, 32'h35);
      chk(wc, 1'h0, "freq select kept");
      @(posedge clk);
      closs <= 1'h1;
      tick(3);
      chk(wcl, 1'h1, "clock loss clear");
      @(posedge clk);
      closs <= 1'h0;
      tick(3);
      chk(wcl, 1'h0, "clock loss gone");
      $display("select test done");
   endtask
   task automatic t_wake();
      nap(1'h0, 1'h0, 1'h1, WAKE_IRQ, 18, 24);
      nap(1'h0, 1'h1, 1'h0, WAKE_IRQ, 18, 24);
      nap(1'h0, 1'h0, 1'h0, WAKE_WDT, 18, 24);
      nap(1'h1, 1'h0, 1'h0, WAKE_WDT, 26, 32);
      nap(1'h1, 1'h1, 1'h1, WAKE_IRQ, 18, 24);
      @(posedge clk);
      wto <= 1'h1;
      wclr <= 1'h1;
      #1 chk({wrst, wcl}, 2'h3, "run timeout");
      @(posedge clk);
      wto <= 1'h0;
      wclr <= 1'h0;
      rd(`OFS_WAKE, 32'h23, "wake status");
      $display("wake test done");
   endtask
   task automatic t_master_clear_n();
      logic v;
      v = 1'h0;
      apb(1'h1, `OFS_TRIM, 32'h80);
      @(posedge clk);
      slp <= 1'h1;
      @(posedge clk);
      slp <= 1'h0;
      master_clear_n_n <= 1'h0;
      tick(5);
      chk(drst, 1'h1, "master clear");
      @(posedge clk);
      master_clear_n_n <= 1'h1;
      repeat (10) begin
         v |= rz;
         tick(1);
      end
      chk(v, 1'h1, "restart at zero");
      chk(run, 1'h1, "run after clear");
      rd(`OFS_TRIM, 32'h0, "trim cleared");
      $display("master clear test done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst_n, psel, pen, pwr, gie, slp, idle, wclr, wto, xtal, lstab, mstab, hstab, closs} = 14'h0000;
      {paddr, pwdata, flags, ens} = 60'h0;
      master_clear_n_n = 1'h1;
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      tick(4);
      t_regs();
      t_slew();
      t_select();
      t_wake();
      t_master_clear_n();
      test_done();
   end
   initial begin
      repeat (6000) @(posedge clk);
      fails++;
      $display("[FAIL] %0t run took too long", $time);
      test_done();
   end
endmodule // testbench
`default_nettype wire
